// ==== aisr_input_ref_select.sv ====
// Overview of operation
// - Bits 4:0 of the input-select register pick port 0 pins 0-7, port 1 pins 4-7 or port 2 pins 0-3.
// - Code 11011 routes the temperature sensor, 11100/11110 battery, 11101 core regulator, 11111 ground.
// - The offset high register reads offset bits 9:2 in its bits 7:0.
// - The offset low register reads offset bits 1:0 in its bits 7:6.
// - Offset low bits 5:0 read zero and ignore writes.
// - Both offset registers are read-only and show the production value fixed per part.
// - The temperature sensor is active only while its enable bit is set.
// - A ground-reference selector picks the ordinary ground pin or the analog ground pin.
// - A reference selector with four choices and the ground choice live in the reference control register.
// - The input-select register decodes at page 0x0, address 0xBB.
// - The offset registers decode at page 0xF, high at 0xBE and low at 0xBD.
// - Reference field 00 external pin, 01 supply pin, 10 1.8 V digital, 11 1.65 V fast reference.
// - Ground select 0 means the ordinary ground pin, 1 the analog ground pin.
// - The sensor enable bit is bit 2 of the reference control register, 1 enables.
module aisr_input_ref_select
   import aisr_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Special-function-register access
   input wire logic [3:0] sfrPage,
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWrite,
   input wire logic sfrRead,
   input wire logic [7:0] sfrWdata,
   output logic [7:0] sfrRdata,
   output logic sfrHit,
   // Production calibration value, held by non-volatile storage
   input wire logic [aisr_pkg::OFFSET_WIDTH-1:0] tempOffsetValue,
   // Analog front-end steering
   output aisr_pkg::aisr_input_route_t inputRoute,
   output aisr_pkg::aisr_ref_ctrl_t refCtrl,
   output logic tempSensorActive
);
   import aisr_pkg::*;

   // ****************************************************************
   // Register state
   // ****************************************************************
   logic [CODE_WIDTH-1:0] inputCode_r;
   logic [CODE_WIDTH-1:0] inputCode_nxt;
   logic [1:0] refSource_r;
   logic [1:0] refSource_nxt;
   logic gndSel_r;
   logic gndSel_nxt;
   logic tempEn_r;
   logic tempEn_nxt;
   logic [OFFSET_WIDTH-1:0] offsetCaught_r;
   logic [OFFSET_WIDTH-1:0] offsetCaught_nxt;
   logic offsetValid_r;
   logic offsetValid_nxt;
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic hitSelect;
   logic hitRefCtrl;
   logic hitOffLow;
   logic hitOffHigh;

   // ****************************************************************
   // Address decode
   // ****************************************************************
   always_comb begin
      hitSelect = (sfrPage == PAGE_MAIN) && (sfrAddr == ADDR_INPUT_SELECT);
      hitRefCtrl = (sfrPage == PAGE_MAIN) && (sfrAddr == ADDR_REFERENCE_CONTROL);
      hitOffLow = (sfrPage == PAGE_CAL) && (sfrAddr == ADDR_TEMP_OFFSET_LOW);
      hitOffHigh = (sfrPage == PAGE_CAL) && (sfrAddr == ADDR_TEMP_OFFSET_HIGH);
      sfrHit = hitSelect | hitRefCtrl | hitOffLow | hitOffHigh;
   end

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   // The offset cannot be a reset value of a flip-flop, so it is caught on
   // the first clock after reset releases and never changes afterwards.
   always_comb begin
      inputCode_nxt = inputCode_r;
      refSource_nxt = refSource_r;
      gndSel_nxt = gndSel_r;
      tempEn_nxt = tempEn_r;
      offsetCaught_nxt = offsetCaught_r;
      offsetValid_nxt = 1'b1;
      rdata_nxt = rdata_r;
      if (!offsetValid_r) begin
         offsetCaught_nxt = tempOffsetValue;
      end
      if (sfrWrite && hitSelect) begin
         inputCode_nxt = sfrWdata[CODE_WIDTH-1:0];
      end
      if (sfrWrite && hitRefCtrl) begin
         gndSel_nxt = sfrWdata[GND_SEL_BIT];
         refSource_nxt = sfrWdata[REF_SRC_LSB +: 2];
         tempEn_nxt = sfrWdata[TEMP_EN_BIT];
      end
      // Writes to either offset register fall through unused.
      if (sfrRead) begin
         rdata_nxt = 8'h00;
         if (hitSelect) begin
            rdata_nxt = {3'h0, inputCode_r};
         end else if (hitRefCtrl) begin
            rdata_nxt[GND_SEL_BIT] = gndSel_r;
            rdata_nxt[REF_SRC_LSB +: 2] = refSource_r;
            rdata_nxt[TEMP_EN_BIT] = tempEn_r;
         end else if (hitOffHigh) begin
            rdata_nxt = offsetCaught_r[OFFSET_WIDTH-1:2];
         end else if (hitOffLow) begin
            rdata_nxt = {offsetCaught_r[1:0], 6'h00};
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         inputCode_r <= INPUT_SELECT_RESET;
         refSource_r <= REF_SRC_RESET;
         gndSel_r <= GND_SEL_RESET;
         tempEn_r <= TEMP_EN_RESET;
         offsetCaught_r <= '0;
         offsetValid_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         inputCode_r <= inputCode_nxt;
         refSource_r <= refSource_nxt;
         gndSel_r <= gndSel_nxt;
         tempEn_r <= tempEn_nxt;
         offsetCaught_r <= offsetCaught_nxt;
         offsetValid_r <= offsetValid_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign sfrRdata = rdata_r;

   // ****************************************************************
   // Input multiplexer decode
   // ****************************************************************
   // Reserved codes leave every route off, so the input floats.
   always_comb begin
      inputRoute = '0;
      if (inputCode_r <= CODE_PORT0_LAST) begin
         inputRoute.port0[inputCode_r[2:0]] = 1'b1;
      end else if ((inputCode_r >= CODE_PORT1_FIRST) && (inputCode_r <= CODE_PORT1_LAST)) begin
         inputRoute.port1High[inputCode_r[1:0]] = 1'b1;
      end else if ((inputCode_r >= CODE_PORT2_FIRST) && (inputCode_r <= CODE_PORT2_LAST)) begin
         inputRoute.port2Low[inputCode_r[1:0]] = 1'b1;
      end else begin
         case (inputCode_r)
            CODE_TEMP_SENSOR: inputRoute.tempSensor = 1'b1;
            CODE_BATTERY_A: inputRoute.battery = 1'b1;
            CODE_BATTERY_B: inputRoute.battery = 1'b1;
            CODE_CORE_REG: inputRoute.coreRegulator = 1'b1;
            CODE_GROUND: inputRoute.ground = 1'b1;
            default: inputRoute = '0;
         endcase
      end
   end

   // ****************************************************************
   // Reference steering
   // ****************************************************************
   always_comb begin
      refCtrl.refSource = aisr_ref_src_t'(refSource_r);
      refCtrl.useAnalogGround = gndSel_r;
      refCtrl.tempSensorEnable = tempEn_r;
      // A sensor sample is only meaningful with both conditions.
      tempSensorActive = tempEn_r && inputRoute.tempSensor;
   end

endmodule : aisr_input_ref_select

// ==== aisr_pkg.sv ====
package aisr_pkg;

   // ****************************************************************
   // Register page and address decode
   // ****************************************************************
   localparam logic [3:0] PAGE_MAIN = 4'h0;
   localparam logic [3:0] PAGE_CAL = 4'hF;
   localparam logic [7:0] ADDR_INPUT_SELECT = 8'hBB;
   localparam logic [7:0] ADDR_TEMP_OFFSET_LOW = 8'hBD;
   localparam logic [7:0] ADDR_TEMP_OFFSET_HIGH = 8'hBE;
   localparam logic [7:0] ADDR_REFERENCE_CONTROL = 8'hD1;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int CODE_WIDTH = 5;
   localparam int OFFSET_WIDTH = 10;
   localparam int GND_SEL_BIT = 5;
   localparam int REF_SRC_LSB = 3;
   localparam int TEMP_EN_BIT = 2;
   localparam logic [4:0] INPUT_SELECT_RESET = 5'h1F;
   localparam logic [1:0] REF_SRC_RESET = 2'h3;
   localparam logic TEMP_EN_RESET = 1'b0;
   localparam logic GND_SEL_RESET = 1'b0;

   // ****************************************************************
   // Input-select codes
   // ****************************************************************
   localparam logic [4:0] CODE_PORT0_FIRST = 5'h00;
   localparam logic [4:0] CODE_PORT0_LAST = 5'h07;
   localparam logic [4:0] CODE_PORT1_FIRST = 5'h0C;
   localparam logic [4:0] CODE_PORT1_LAST = 5'h0F;
   localparam logic [4:0] CODE_PORT2_FIRST = 5'h10;
   localparam logic [4:0] CODE_PORT2_LAST = 5'h13;
   localparam logic [4:0] CODE_TEMP_SENSOR = 5'h1B;
   localparam logic [4:0] CODE_BATTERY_A = 5'h1C;
   localparam logic [4:0] CODE_CORE_REG = 5'h1D;
   localparam logic [4:0] CODE_BATTERY_B = 5'h1E;
   localparam logic [4:0] CODE_GROUND = 5'h1F;

   // Reference source field encoding.
   typedef enum logic [1:0] {
      AISR_REF_EXT_PIN = 2'b00,
      AISR_REF_SUPPLY_PIN = 2'b01,
      AISR_REF_DIGITAL_1V8 = 2'b10,
      AISR_REF_FAST_1V65 = 2'b11
   } aisr_ref_src_t;

   // One-hot steering of the positive converter input.
   typedef struct packed {
      logic [7:0] port0;
      logic [3:0] port1High;
      logic [3:0] port2Low;
      logic tempSensor;
      logic battery;
      logic coreRegulator;
      logic ground;
   } aisr_input_route_t;

   // Reference steering toward the analog front end.
   typedef struct packed {
      aisr_ref_src_t refSource;
      logic useAnalogGround;
      logic tempSensorEnable;
   } aisr_ref_ctrl_t;

endpackage : aisr_pkg

// ==== aisr_select_properties.sv ====
module aisr_select_properties
   import aisr_pkg::*;
(
   // Watched ports
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [3:0] sfrPage,
   input wire logic [7:0] sfrAddr,
   input wire logic sfrWrite,
   input wire logic sfrRead,
   input wire logic [7:0] sfrWdata,
   input wire logic [7:0] sfrRdata,
   input wire logic sfrHit,
   input wire logic [aisr_pkg::OFFSET_WIDTH-1:0] tempOffsetValue,
   input wire aisr_pkg::aisr_input_route_t inputRoute,
   input wire aisr_pkg::aisr_ref_ctrl_t refCtrl,
   input wire logic tempSensorActive
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   wire logic onMain = sfrPage == 4'h0;
   wire logic onCal = sfrPage == 4'hF;
   wire logic selWr = sfrWrite && onMain && sfrAddr == 8'hBB;
   wire logic [2:0] pin = sfrWdata[2:0];
   wire logic [3:0] refIn = {sfrWdata[4:3], sfrWdata[5], sfrWdata[2]};
   // The offset is caught at the first edge after reset, so that edge is left out.
   sequence rdCal(logic [7:0] a);
      sfrRead && onCal && sfrAddr == a && !$past(rst);
   endsequence
   route_temp_a: assert property (selWr && sfrWdata[4:0] == 5'h1B |=> inputRoute == 20'h00008)
      else $error("sensor code did not route the sensor alone");
   route_port0_a: assert property (selWr && sfrWdata[4:3] == 2'h0 |=> inputRoute.port0 == 8'h01 << $past(pin))
      else $error("port 0 code routed the wrong pin");
   offset_high_a: assert property (rdCal(8'hBE) |=> sfrRdata == tempOffsetValue[9:2])
      else $error("offset high byte wrong");
   offset_low_a: assert property (rdCal(8'hBD) |=> sfrRdata == {tempOffsetValue[1:0], 6'h00})
      else $error("offset low byte wrong");
   hit_decode_a: assert property (sfrHit == (onMain && (sfrAddr == 8'hBB || sfrAddr == 8'hD1) || onCal && (sfrAddr == 8'hBD || sfrAddr == 8'hBE)))
      else $error("register decode wrong");
   sensor_on_a: assert property (tempSensorActive == (refCtrl.tempSensorEnable && inputRoute.tempSensor))
      else $error("sensor active flag wrong");
   ref_write_a: assert property (sfrWrite && onMain && sfrAddr == 8'hD1 |=> refCtrl == $past(refIn))
      else $error("reference control not taken");
   sel_upper_a: assert property (sfrRead && onMain && sfrAddr == 8'hBB |=> sfrRdata[7:5] == 3'h0)
      else $error("select upper bits not zero");
endmodule : aisr_select_properties

bind aisr_input_ref_select aisr_select_properties i_aisr_select_properties (.sys_clk, .rst,
   .sfrPage, .sfrAddr, .sfrWrite, .sfrRead, .sfrWdata, .sfrRdata, .sfrHit, .tempOffsetValue,
   .inputRoute, .refCtrl, .tempSensorActive);

// ==== test_aisr_input_ref_select.sv ====
`define CHK(n, e, g) begin nCompared++; if ((g) !== (e)) begin nErrors++; \
   $display("wrong value %s expected %h seen %h", n, e, g); end end
module test_aisr_input_ref_select
   import aisr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, rst = 1, sfrWrite = 0, sfrRead = 0, sfrHit, tempSensorActive;
   logic [3:0] sfrPage = 4'h0;
   logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata;
   logic [9:0] tempOffsetValue = 10'h2A5;
   aisr_input_route_t inputRoute;
   aisr_ref_ctrl_t refCtrl;
   int nErrors = 0, nCompared = 0, cyc = 0;
   aisr_input_ref_select i_aisr_input_ref_select (.sys_clk, .rst, .sfrPage, .sfrAddr, .sfrWrite,
      .sfrRead, .sfrWdata, .sfrRdata, .sfrHit, .tempOffsetValue, .inputRoute, .refCtrl,
      .tempSensorActive);
   initial forever #4 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         nErrors++;
         wrap_up();
      end
   end
   task wr(input logic [3:0] p, input logic [7:0] a, d);
      @(posedge sys_clk);
      {sfrPage, sfrAddr, sfrWdata, sfrWrite} <= {p, a, d, 1'b1};
      @(posedge sys_clk);
      sfrWrite <= 0;
      @(negedge sys_clk);
   endtask : wr
   task rd(input logic [3:0] p, input logic [7:0] a, e, input string n);
      @(posedge sys_clk);
      {sfrPage, sfrAddr, sfrRead} <= {p, a, 1'b1};
      @(posedge sys_clk);
      sfrRead <= 0;
      @(negedge sys_clk);
      `CHK(n, e, sfrRdata)
   endtask : rd
   function automatic aisr_input_route_t expRoute(logic [4:0] c);
      aisr_input_route_t r = '0;
      if (c < 5'h08) r.port0[c[2:0]] = 1;
      else if (c >= 5'h0C && c < 5'h14) {r.port2Low, r.port1High} = 8'h01 << (c - 5'h0C);
      r.tempSensor = c == 5'h1B;
      r.battery = c == 5'h1C || c == 5'h1E;
      r.coreRegulator = c == 5'h1D;
      r.ground = c == 5'h1F;
      return r;
   endfunction : expRoute
   task t_codes;
      for (int c = 0; c < 32; c++) begin
         wr(4'h0, 8'hBB, {3'h7, c[4:0]});
         `CHK("route", expRoute(c[4:0]), inputRoute)
         rd(4'h0, 8'hBB, {3'h0, c[4:0]}, "select");
      end
      wr(4'h0, 8'hBB, 8'h00);
      wr(4'hF, 8'hBB, 8'h1F);
      `CHK("route", expRoute(5'h00), inputRoute)
      $display("codes done");
   endtask : t_codes
   task t_offset;
      wr(4'hF, 8'hBE, 8'h00);
      wr(4'hF, 8'hBD, 8'hFF);
      rd(4'hF, 8'hBE, 8'hA9, "offset high");
      rd(4'hF, 8'hBD, 8'h40, "offset low");
      rd(4'h0, 8'hBE, 8'h00, "unmapped");
      $display("offset done");
   endtask : t_offset
   task t_ref;
      wr(4'h0, 8'hBB, 8'h1B);
      for (int v = 0; v < 16; v++) begin
         wr(4'h0, 8'hD1, {2'h3, v[3:0], 2'h3});
         `CHK("ref", {v[2:1], v[3], v[0]}, refCtrl)
         `CHK("sensor", v[0], tempSensorActive)
         rd(4'h0, 8'hD1, {2'h0, v[3:0], 2'h0}, "ref read");
      end
      $display("reference done");
   endtask : t_ref
   task wrap_up;
      $display("compared %0d errors %0d", nCompared, nErrors);
      if (nErrors == 0 && nCompared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 0;
      `CHK("ground", 20'h00001, inputRoute)
      `CHK("ref reset", 4'hC, refCtrl)
      rd(4'h0, 8'hBB, 8'h1F, "select reset");
      t_codes();
      t_offset();
      t_ref();
      wrap_up();
   end
endmodule : test_aisr_input_ref_select
